// ===== rtl/led_driver_powerup_sequencer.sv
/*
 * Power-up and fault sequencer for a two-channel boost LED driver:
 * enable qualification, disconnect switch, LED pin detection, soft
 * start, undervoltage levels, overcurrent and enable-low shutdown.
 * Assumes all comparator flags and the switching clock arrive as
 * asynchronous pins; the analog loop acts on the outputs.
 */
// Summary of operation
// - Start on long enable pulse, undervoltage clear
// - Frequency pin held low keeps device off
// - System check precedes any LED sink enable
// - Disconnect switch on, then check sink pins
// - Detection waits for gate-ready comparator
// - Wait 3000-4000 switching cycles before deciding
// - Classify pins: shorted, unused, or in use
// - Short halts power-up; recheck after release
// - Unused pin removed from regulation loop
// - Above twice trip current, shut down quickly
// - One-to-two times trip, shut down after 10000
// - After startup use lower undervoltage stop level
// - Soft start with reduced currents before regulation
// - Enable low 32750 cycles enters low power
`timescale 1ns/1ps

module led_driver_powerup_sequencer #(
	parameter int OC1_COUNT    = powerup_seq_pkg::OC1_SW,    // 1x-2x overcurrent delay
	parameter int EN_LOW_COUNT = powerup_seq_pkg::EN_LOW_SW  // Enable-low shutdown delay
) (
	input  wire logic                              clk_i,                 // 40 MHz clock
	input  wire logic                              rst_n_i,               // Sync reset, low
	input  wire logic                              dim_enable_i,          // Enable/dimming pin
	input  wire logic                              uv_start_i,            // Below start level
	input  wire logic                              uv_stop_i,             // Below stop level
	input  wire logic                              freq_set_sync_low_i,   // Freq pin held low
	input  wire logic                              gate_ready_i,          // Gate at VIN-offset
	input  wire logic                              sw_clk_i,              // Switching clock
	input  wire logic [powerup_seq_pkg::NUM_CH-1:0] led_above_low_i,       // Pin above 120 mV
	input  wire logic [powerup_seq_pkg::NUM_CH-1:0] led_short_i,           // Pin below 70 mV
	input  wire logic [powerup_seq_pkg::NUM_CH-1:0] led_in_use_i,          // Pin at upper level
	input  wire logic                              sense_over_1x_i,       // Above trip
	input  wire logic                              sense_over_2x_i,       // Above twice trip
	input  wire logic                              softstart_done_i,      // Sinks have headroom
	output logic                                   disconnect_gate_on_o,  // Switch drive on
	output logic      [powerup_seq_pkg::NUM_CH-1:0] sink_enable_o,         // Sink on per channel
	output logic      [powerup_seq_pkg::NUM_CH-1:0] regulation_mask_o,     // Channel in loop
	output logic      [powerup_seq_pkg::NUM_CH-1:0] channel_unused_o,      // Removed channel
	output logic                                   soft_start_o,          // Reduced currents
	output logic                                   startup_done_o,        // Full regulation
	output logic                                   uv_stop_select_o,      // Lower UV level
	output logic                                   short_halt_o,          // Halted on short
	output logic                                   overcurrent_fault_o,   // Overcurrent latched
	output logic                                   low_power_o            // Low-power shutdown
);

	localparam int N  = powerup_seq_pkg::NUM_CH; // Channel count
	localparam int NS = 9 + 3 * N;               // Pins through synchroniser

	// ************************************************
	// Synchronised pin levels
	// ************************************************
	logic [NS-1:0] pins_raw;   // All asynchronous pins
	logic [NS-1:0] pins_s;     // Their synchronised levels
	logic          en_s;       // Enable high
	logic          uv_start_s; // Below start level
	logic          uv_stop_s;  // Below stop level
	logic          fset_low_s; // Frequency pin low
	logic          gate_rdy_s; // Gate comparator tripped
	logic          swclk_s;    // Switching clock level
	logic          oc1_s;      // Above trip current
	logic          oc2_s;      // Above twice trip
	logic          ss_done_s;  // Soft start finished
	logic [N-1:0]  above_s;    // Pins above low threshold
	logic [N-1:0]  short_s;    // Pins shorted
	logic [N-1:0]  in_use_s;   // Pins at in-use level

	assign pins_raw = {led_in_use_i, led_short_i, led_above_low_i, softstart_done_i,
		sense_over_2x_i, sense_over_1x_i, sw_clk_i, gate_ready_i, freq_set_sync_low_i,
		uv_stop_i, uv_start_i, dim_enable_i};

	// One synchroniser for every pin
	pin_sync3 #(
		.W (NS)
	) u_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.pin_i   (pins_raw),
		.level_o (pins_s)
	);

	// Unpack the synchronised levels
	assign en_s       = pins_s[0];
	assign uv_start_s = pins_s[1];
	assign uv_stop_s  = pins_s[2];
	assign fset_low_s = pins_s[3];
	assign gate_rdy_s = pins_s[4];
	assign swclk_s    = pins_s[5];
	assign oc1_s      = pins_s[6];
	assign oc2_s      = pins_s[7];
	assign ss_done_s  = pins_s[8];
	assign above_s    = pins_s[9 +: N];
	assign short_s    = pins_s[9 + N +: N];
	assign in_use_s   = pins_s[9 + 2 * N +: N];

	// ************************************************
	// Switching clock tick
	// ************************************************
	logic swclk_d_ff; // Previous switching clock level
	logic sw_tick;    // Rising edge of switching clock

	// Edge detect on the accepted level
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			swclk_d_ff <= 1'b0;
		end else begin
			swclk_d_ff <= swclk_s;
		end
	end

	assign sw_tick = swclk_s && !swclk_d_ff;

	// ************************************************
	// State and counters
	// ************************************************
	powerup_seq_pkg::seq_state_t state_ff;  // Sequencer state
	powerup_seq_pkg::seq_state_t nxt_state;
	logic [5:0]   pulse_ff;     // Enable-high clock cycles while off
	logic [5:0]   nxt_pulse;
	logic         pulse_ok;     // First pulse long enough
	logic [N-1:0] det_done;     // Channel detection delay elapsed
	logic         oc1_done;     // 1x overcurrent lasted long enough
	logic         en_low_done;  // Enable low long enough
	logic         powered;      // Any powered state
	logic         uv_now;       // Undervoltage at the level in force

	// Per-channel detection delay counters
	generate
		for (genvar c = 0; c < N; c++) begin : g_det
			tick_counter #(
				.W    (powerup_seq_pkg::CNT_W),
				.TERM (powerup_seq_pkg::DETECT_SW)
			) u_det (
				.clk_i   (clk_i),
				.rst_n_i (rst_n_i),
				.clear_i ((state_ff != powerup_seq_pkg::S_DETECT) || !above_s[c]),
				.tick_i  (sw_tick),
				.done_o  (det_done[c])
			);
		end
	endgenerate

	// Continuous 1x-2x overcurrent delay
	tick_counter #(
		.W    (powerup_seq_pkg::CNT_W),
		.TERM (OC1_COUNT)
	) u_oc1 (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.clear_i (!oc1_s || !powered),
		.tick_i  (sw_tick),
		.done_o  (oc1_done)
	);

	// Enable-low shutdown delay
	tick_counter #(
		.W    (powerup_seq_pkg::CNT_W),
		.TERM (EN_LOW_COUNT)
	) u_enlow (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.clear_i (en_s || (state_ff == powerup_seq_pkg::S_OFF)),
		.tick_i  (sw_tick),
		.done_o  (en_low_done)
	);

	// Powered means switch on and not latched off
	assign powered = (state_ff != powerup_seq_pkg::S_OFF)
		&& (state_ff != powerup_seq_pkg::S_FAULT);
	// Lower stop level once startup is done
	assign uv_now  = (state_ff == powerup_seq_pkg::S_RUN) ? uv_stop_s : uv_start_s;
	assign pulse_ok = (pulse_ff >= 6'(powerup_seq_pkg::FIRST_PULSE_CYC));

	// ************************************************
	// Output registers
	// ************************************************
	logic         gate_on_ff;   // Switch drive
	logic [N-1:0] sink_en_ff;   // Sink enables
	logic [N-1:0] reg_mask_ff;  // Channels in loop
	logic [N-1:0] unused_ff;    // Channels removed
	logic         soft_ff;      // Soft start
	logic         run_ff;       // Startup done
	logic         short_ff;     // Short halt
	logic         fault_ff;     // Overcurrent latched
	logic         lowpwr_ff;    // Low-power shutdown
	logic         nxt_gate_on;
	logic [N-1:0] nxt_sink_en;
	logic [N-1:0] nxt_reg_mask;
	logic [N-1:0] nxt_unused;
	logic         nxt_soft;
	logic         nxt_run;
	logic         nxt_short;
	logic         nxt_fault;
	logic         nxt_lowpwr;

	// ************************************************
	// Next state and outputs
	// ************************************************
	always_comb begin
		nxt_state  = state_ff;
		nxt_unused = unused_ff;
		nxt_lowpwr = lowpwr_ff;
		// Measure the first enable pulse while off
		if (en_s && (state_ff == powerup_seq_pkg::S_OFF)) begin
			nxt_pulse = pulse_ok ? pulse_ff : pulse_ff + 6'h01;
		end else begin
			nxt_pulse = 6'h00;
		end
		case (state_ff)
			// Wait for qualified start
			powerup_seq_pkg::S_OFF: begin
				if (en_s && pulse_ok && !uv_start_s && !fset_low_s) begin
					nxt_state  = powerup_seq_pkg::S_GATE;
					nxt_unused = '0;
					nxt_lowpwr = 1'b0;
				end
			end
			// Switch turning on
			powerup_seq_pkg::S_GATE: begin
				if (gate_rdy_s) begin
					nxt_state = powerup_seq_pkg::S_DETECT;
				end
			end
			// Pin detection, short halts at once
			powerup_seq_pkg::S_DETECT: begin
				if (|short_s) begin
					nxt_state = powerup_seq_pkg::S_SHORT;
				end else if (&det_done) begin
					nxt_state  = powerup_seq_pkg::S_SOFT;
					nxt_unused = ~in_use_s;
				end
			end
			// Halted until the short clears, then recheck
			powerup_seq_pkg::S_SHORT: begin
				if (!(|short_s)) begin
					nxt_state = powerup_seq_pkg::S_DETECT;
				end
			end
			// Soft start until sinks have headroom
			powerup_seq_pkg::S_SOFT: begin
				if (ss_done_s) begin
					nxt_state = powerup_seq_pkg::S_RUN;
				end
			end
			// Regulating, or latched off
			powerup_seq_pkg::S_RUN, powerup_seq_pkg::S_FAULT: begin
				nxt_state = state_ff;
			end
			default: begin
				nxt_state = powerup_seq_pkg::S_OFF;
			end
		endcase
		// Supply and frequency pin drop the device
		if (powered && (uv_now || fset_low_s)) begin
			nxt_state = powerup_seq_pkg::S_OFF;
		end
		// Overcurrent latches off
		if (powered && (oc2_s || oc1_done)) begin
			nxt_state = powerup_seq_pkg::S_FAULT;
		end
		// Long enable low ends everything
		if ((state_ff != powerup_seq_pkg::S_OFF) && en_low_done) begin
			nxt_state  = powerup_seq_pkg::S_OFF;
			nxt_lowpwr = 1'b1;
		end
		// Outputs follow the next state
		nxt_gate_on  = (nxt_state != powerup_seq_pkg::S_OFF)
			&& (nxt_state != powerup_seq_pkg::S_FAULT);
		nxt_soft     = (nxt_state == powerup_seq_pkg::S_SOFT);
		nxt_run      = (nxt_state == powerup_seq_pkg::S_RUN);
		nxt_short    = (nxt_state == powerup_seq_pkg::S_SHORT);
		nxt_fault    = (nxt_state == powerup_seq_pkg::S_FAULT);
		nxt_reg_mask = (nxt_soft || nxt_run) ? ~nxt_unused : '0;
		nxt_sink_en  = en_s ? nxt_reg_mask : '0;
	end

	// Register state, counters and outputs
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_ff    <= powerup_seq_pkg::STATE_RST;
			pulse_ff    <= 6'h00;
			gate_on_ff  <= 1'b0;
			sink_en_ff  <= '0;
			reg_mask_ff <= '0;
			unused_ff   <= '0;
			soft_ff     <= 1'b0;
			run_ff      <= 1'b0;
			short_ff    <= 1'b0;
			fault_ff    <= 1'b0;
			lowpwr_ff   <= 1'b0;
		end else begin
			state_ff    <= nxt_state;
			pulse_ff    <= nxt_pulse;
			gate_on_ff  <= nxt_gate_on;
			sink_en_ff  <= nxt_sink_en;
			reg_mask_ff <= nxt_reg_mask;
			unused_ff   <= nxt_unused;
			soft_ff     <= nxt_soft;
			run_ff      <= nxt_run;
			short_ff    <= nxt_short;
			fault_ff    <= nxt_fault;
			lowpwr_ff   <= nxt_lowpwr;
		end
	end

	// ************************************************
	// Port drive
	// ************************************************
	assign disconnect_gate_on_o = gate_on_ff;
	assign sink_enable_o        = sink_en_ff;
	assign regulation_mask_o    = reg_mask_ff;
	assign channel_unused_o     = unused_ff;
	assign soft_start_o         = soft_ff;
	assign startup_done_o       = run_ff;
	assign uv_stop_select_o     = run_ff;
	assign short_halt_o         = short_ff;
	assign overcurrent_fault_o  = fault_ff;
	assign low_power_o          = lowpwr_ff;

endmodule : led_driver_powerup_sequencer

// ===== rtl/powerup_seq_pkg.sv
/*
 * Package for the LED driver power-up sequencer: state codes, timing
 * constants and channel count.
 * Assumes a 40 MHz system clock and a switching clock seen as a pin.
 */
package powerup_seq_pkg;

	// ************************************************
	// Clock and channels
	// ************************************************
	localparam int CLK_MHZ      = 40;   // System clock rate
	localparam int NUM_CH       = 2;    // LED sink channels
	localparam int CNT_W        = 16;   // Width of switching-cycle counters

	// ************************************************
	// Timing in its own units and as cycle counts
	// ************************************************
	localparam int FIRST_PULSE_NS  = 750;  // Least first enable pulse
	localparam int FIRST_PULSE_CYC = (FIRST_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int OC2_MAX_NS      = 3000; // Longest 2x overcurrent reaction
	localparam int OC2_MAX_CYC     = (OC2_MAX_NS * CLK_MHZ) / 1000;
	localparam int DETECT_MIN_SW   = 3000; // Least detect delay, sw cycles
	localparam int DETECT_MAX_SW   = 4000; // Longest detect delay, sw cycles
	localparam int DETECT_SW       = 3500; // Terminal count used
	localparam int OC1_SW          = 10000; // 1x-2x overcurrent delay
	localparam int EN_LOW_SW       = 32750; // Enable-low shutdown delay
	localparam int SYNC_STAGES     = 3;    // Pin synchroniser depth

	// ************************************************
	// Sequencer states, one-hot
	// ************************************************
	typedef enum logic [6:0] {
		S_OFF    = 7'h01, // Powered down
		S_GATE   = 7'h02, // Disconnect switch turning on
		S_DETECT = 7'h04, // LED pin detection
		S_SHORT  = 7'h08, // Halted on shorted pin
		S_SOFT   = 7'h10, // Soft start
		S_RUN    = 7'h20, // Full regulation
		S_FAULT  = 7'h40  // Overcurrent shutdown
	} seq_state_t;

	localparam seq_state_t STATE_RST = S_OFF; // State after reset

endpackage : powerup_seq_pkg

// ===== rtl/pin_sync3.sv
/*
 * Three-flop pin synchroniser: output takes a new value once the
 * second and third stages agree.
 * Assumes inputs are asynchronous levels from analog comparators or pins.
 */
`timescale 1ns/1ps

module pin_sync3 #(
	parameter int W = 1 // Number of pins
) (
	input  wire logic         clk_i,   // System clock
	input  wire logic         rst_n_i, // Synchronous reset, active low
	input  wire logic [W-1:0] pin_i,   // Asynchronous pin levels
	output logic      [W-1:0] level_o  // Filtered, synchronised levels
);

	logic [W-1:0] meta_ff;  // First stage, read only by second
	logic [W-1:0] s2_ff;    // Second stage
	logic [W-1:0] s3_ff;    // Third stage
	logic [W-1:0] level_ff; // Accepted level
	logic [W-1:0] nxt_level;

	// ************************************************
	// Accept a change once stages two and three agree
	// ************************************************
	always_comb begin
		nxt_level = (s2_ff & s3_ff) | (level_ff & (s2_ff | s3_ff));
	end

	// Register the stages
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			meta_ff  <= '0;
			s2_ff    <= '0;
			s3_ff    <= '0;
			level_ff <= '0;
		end else begin
			meta_ff  <= pin_i;
			s2_ff    <= meta_ff;
			s3_ff    <= s2_ff;
			level_ff <= nxt_level;
		end
	end

	assign level_o = level_ff;

endmodule : pin_sync3

// ===== rtl/tick_counter.sv
/*
 * Saturating counter of switching-clock ticks with a terminal flag.
 * Assumes tick_i is a one-cycle pulse in the system clock domain.
 */
`timescale 1ns/1ps

module tick_counter #(
	parameter int W    = 16,  // Counter width
	parameter int TERM = 3500 // Terminal count
) (
	input  wire logic clk_i,   // System clock
	input  wire logic rst_n_i, // Synchronous reset, active low
	input  wire logic clear_i, // Restart from zero
	input  wire logic tick_i,  // One switching-clock tick
	output logic      done_o   // Terminal count reached
);

	logic [W-1:0] cnt_ff;  // Ticks so far
	logic [W-1:0] nxt_cnt;
	logic         at_term; // Saturated at terminal

	// ************************************************
	// Count, clear wins, hold at terminal
	// ************************************************
	always_comb begin
		at_term = (cnt_ff == W'(TERM));
		nxt_cnt = cnt_ff;
		if (clear_i) begin
			nxt_cnt = '0;
		end else if (tick_i && !at_term) begin
			nxt_cnt = cnt_ff + W'(1);
		end
	end

	// Register the count
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign done_o = at_term;

endmodule : tick_counter

// ===== verification/led_driver_powerup_sequencer_chk.sv
/*
 * Port checker for the power-up sequencer, bound to its ports.
 * Assumes clean pin levels and a switching clock below clk/4.
 */
`timescale 1ns/1ps

module led_driver_powerup_sequencer_chk #(
	parameter int OC1_COUNT    = 20, // 1x overcurrent delay, ticks
	parameter int EN_LOW_COUNT = 40  // Enable-low delay, ticks
) (
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic       dim_enable_i,
	input wire logic       uv_start_i,
	input wire logic       uv_stop_i,
	input wire logic       freq_set_sync_low_i,
	input wire logic       sw_clk_i,
	input wire logic [1:0] led_above_low_i,
	input wire logic       sense_over_1x_i,
	input wire logic       sense_over_2x_i,
	input wire logic       disconnect_gate_on_o,
	input wire logic [1:0] sink_enable_o,
	input wire logic [1:0] regulation_mask_o,
	input wire logic [1:0] channel_unused_o,
	input wire logic       soft_start_o,
	input wire logic       startup_done_o,
	input wire logic       short_halt_o,
	input wire logic       overcurrent_fault_o,
	input wire logic       low_power_o
);
	// ************************************************
	// Tick counters seen from the pins
	// ************************************************
	logic        sw_q;  // Last switching clock level
	logic        tick;  // Rising switching clock edge
	logic [7:0]  two_q; // Recent 2x overcurrent history
	logic [15:0] lo_t;  // Ticks with enable low
	logic [15:0] oc_t;  // Ticks with 1x overcurrent
	logic [15:0] det_t; // Ticks with both pins above low

	assign tick = sw_clk_i & ~sw_q;

	// Counters saturate so long runs never wrap
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sw_q  <= 1'h0;
			two_q <= 8'h00;
			lo_t  <= 16'h0000;
			oc_t  <= 16'h0000;
			det_t <= 16'h0000;
		end else begin
			sw_q  <= sw_clk_i;
			two_q <= {two_q[6:0], sense_over_2x_i};
			lo_t  <= dim_enable_i ? 16'h0000 : lo_t + 16'(tick & ~&lo_t);
			oc_t  <= sense_over_1x_i ? oc_t + 16'(tick & ~&oc_t) : 16'h0000;
			det_t <= &led_above_low_i ? det_t + 16'(tick & ~&det_t) : 16'h0000;
		end
	end

	// ************************************************
	// Assertions
	// ************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sink_gate_a: assert property (sink_enable_o != 2'h0 |-> soft_start_o || startup_done_o)
		else $error("sink on outside soft start or run");
	sink_mask_a: assert property ((sink_enable_o & ~regulation_mask_o) == 2'h0)
		else $error("sink on outside regulation mask");
	unused_out_a: assert property ($rose(soft_start_o) |-> regulation_mask_o == ~channel_unused_o)
		else $error("unused channel kept in loop");
	fault_off_a: assert property (overcurrent_fault_o |-> !disconnect_gate_on_o && sink_enable_o == 2'h0)
		else $error("switch or sink on during fault");
	fast_trip_a: assert property (sense_over_2x_i && disconnect_gate_on_o |->
		##[1:120] overcurrent_fault_o)
		else $error("2x overcurrent not tripped in time");
	freq_hold_a: assert property (freq_set_sync_low_i [*8] |-> !disconnect_gate_on_o)
		else $error("powered while frequency pin low");
	start_cause_a: assert property ($rose(disconnect_gate_on_o) |-> $past(dim_enable_i, 8) &&
		$past(dim_enable_i, 30) && !$past(uv_start_i, 8) && !$past(freq_set_sync_low_i, 8))
		else $error("start without a valid enable");
	low_power_a: assert property ($rose(low_power_o) |-> lo_t >= EN_LOW_COUNT - 1)
		else $error("low power entered too early");
	en_low_off_a: assert property (lo_t > EN_LOW_COUNT + 1 |-> !disconnect_gate_on_o)
		else $error("still powered after long enable low");
	oc_delay_a: assert property ($rose(overcurrent_fault_o) |->
		oc_t >= OC1_COUNT - 1 || two_q != 8'h00)
		else $error("1x overcurrent tripped too early");
	detect_wait_a: assert property ($rose(soft_start_o) |->
		det_t >= powerup_seq_pkg::DETECT_MIN_SW - 1)
		else $error("detection decided too early");
	short_halt_a: assert property (short_halt_o |-> sink_enable_o == 2'h0 && !soft_start_o)
		else $error("progress while halted on short");
	uv_level_a: assert property (uv_stop_i [*8] |-> !startup_done_o && !disconnect_gate_on_o)
		else $error("running below stop level");
	soft_order_a: assert property ($rose(startup_done_o) |-> $past(soft_start_o))
		else $error("regulation without soft start");

endmodule : led_driver_powerup_sequencer_chk

bind led_driver_powerup_sequencer led_driver_powerup_sequencer_chk #(
	.OC1_COUNT(OC1_COUNT), .EN_LOW_COUNT(EN_LOW_COUNT)) u_chk (
	.clk_i, .rst_n_i, .dim_enable_i, .uv_start_i, .uv_stop_i, .freq_set_sync_low_i,
	.sw_clk_i, .led_above_low_i, .sense_over_1x_i, .sense_over_2x_i, .disconnect_gate_on_o,
	.sink_enable_o, .regulation_mask_o, .channel_unused_o, .soft_start_o,
	.startup_done_o, .short_halt_o, .overcurrent_fault_o, .low_power_o);

// ===== verification/led_string_model.sv
/*
 * Far side model: switching clock, gate comparator, LED pin comparators.
 * Assumes the bench commands shorts, unused pins and pin dropouts.
 */
`timescale 1ns/1ps

module led_string_model (
	input  wire logic       clk_i,        // System clock
	input  wire logic       gate_on_i,    // Switch drive
	input  wire logic       soft_i,       // Soft start active
	input  wire logic [1:0] short_cmd_i,  // Pins shorted to ground
	input  wire logic [1:0] unused_cmd_i, // Pins with pull-down only
	input  wire logic       drop_i,       // Pins fall below low level
	output logic            sw_clk_o,     // Switching clock
	output logic            gate_ready_o, // Gate at supply minus offset
	output logic            ss_done_o,    // Sinks have headroom
	output logic      [1:0] above_low_o,  // Pin above low level
	output logic      [1:0] short_o,      // Pin below short level
	output logic      [1:0] in_use_o      // Pin at in-use level
);
	int gcnt = 0; // Gate charge time
	int scnt = 0; // Output capacitor charge time

	// Free-running oscillator, period 152 ns, off the clk phase
	initial sw_clk_o = 1'h0;
	always #76 sw_clk_o = ~sw_clk_o;

	// Gate charges slowly once the switch is on, output only during soft start
	always @(posedge clk_i) begin
		gcnt <= !gate_on_i ? 0 : gcnt + int'(gcnt < 10);
		scnt <= !gate_on_i ? 0 : scnt + int'(soft_i && scnt < 10);
	end

	assign gate_ready_o = gcnt == 10;
	assign ss_done_o    = scnt == 10;
	// Shorts show at once, other levels once the gate charges
	assign short_o      = short_cmd_i;
	assign above_low_o  = {2{gate_ready_o & ~drop_i}} & ~short_cmd_i;
	assign in_use_o     = above_low_o & ~unused_cmd_i;

endmodule : led_string_model

// ===== verification/led_driver_powerup_sequencer_test.sv
/*
 * Self-checking bench for the power-up sequencer.
 * Assumes the LED string model and the bound checker.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("wrong value %s exp %h got %h", n, e, g); end end

module led_driver_powerup_sequencer_test;
	localparam int OC1 = 20; // Short 1x overcurrent delay
	localparam int ENL = 40; // Short enable-low delay
	logic       clk_i = 1'h0, rst_n_i = 1'h0, dim_enable_i = 1'h0, uv_start_i = 1'h0;
	logic       uv_stop_i = 1'h0, freq_set_sync_low_i = 1'h0, sense_over_1x_i = 1'h0;
	logic       sense_over_2x_i = 1'h0, drop = 1'h0;
	logic [1:0] short_cmd = 2'h0, unused_cmd = 2'h0;
	logic       sw_clk_i, gate_ready_i, softstart_done_i, disconnect_gate_on_o, soft_start_o;
	logic       startup_done_o, uv_stop_select_o, short_halt_o, overcurrent_fault_o, low_power_o;
	logic [1:0] led_above_low_i, led_short_i, led_in_use_i, sink_enable_o;
	logic [1:0] regulation_mask_o, channel_unused_o;
	int         error_cnt = 0, check_count = 0, cyc = 0;

	led_driver_powerup_sequencer #(.OC1_COUNT(OC1), .EN_LOW_COUNT(ENL)) dut (
		.clk_i, .rst_n_i, .dim_enable_i, .uv_start_i, .uv_stop_i, .freq_set_sync_low_i,
		.gate_ready_i, .sw_clk_i, .led_above_low_i, .led_short_i, .led_in_use_i,
		.sense_over_1x_i, .sense_over_2x_i, .softstart_done_i, .disconnect_gate_on_o,
		.sink_enable_o, .regulation_mask_o, .channel_unused_o, .soft_start_o,
		.startup_done_o, .uv_stop_select_o, .short_halt_o, .overcurrent_fault_o, .low_power_o);

	led_string_model far (
		.clk_i, .gate_on_i(disconnect_gate_on_o), .soft_i(soft_start_o), .short_cmd_i(short_cmd),
		.unused_cmd_i(unused_cmd), .drop_i(drop), .sw_clk_o(sw_clk_i), .gate_ready_o(gate_ready_i),
		.ss_done_o(softstart_done_i), .above_low_o(led_above_low_i), .short_o(led_short_i),
		.in_use_o(led_in_use_i));

	always #12.5 clk_i = ~clk_i;

	// Inputs change at the falling edge only
	task automatic clks(input int n);
		repeat (n) @(negedge clk_i);
	endtask : clks

	task automatic ticks(input int n);
		repeat (n) @(posedge sw_clk_i);
		@(negedge clk_i);
	endtask : ticks

	task automatic start();
		dim_enable_i = 1'h1;
		clks(45);
		`CHK("gate on", 1'h1, disconnect_gate_on_o)
		`CHK("sinks off", 2'h0, sink_enable_o)
		`CHK("low power clear", 1'h0, low_power_o)
	endtask : start

	task automatic stop();
		dim_enable_i = 1'h0;
		ticks(ENL + 4);
		`CHK("low power", 1'h1, low_power_o)
		`CHK("gate off", 1'h0, disconnect_gate_on_o)
	endtask : stop

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report

	// Hang guard, well above the expected run
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			final_report();
		end
	end

	initial begin
		clks(8);
		rst_n_i = 1'h1;
		clks(2);
		`CHK("reset gate", 1'h0, disconnect_gate_on_o)
		// Refused starts: pin low, undervoltage, short pulse
		freq_set_sync_low_i = 1'h1;
		dim_enable_i = 1'h1;
		clks(60);
		`CHK("freq low", 1'h0, disconnect_gate_on_o)
		freq_set_sync_low_i = 1'h0;
		uv_start_i = 1'h1;
		clks(60);
		`CHK("uv start", 1'h0, disconnect_gate_on_o)
		uv_start_i = 1'h0;
		dim_enable_i = 1'h0;
		clks(10);
		dim_enable_i = 1'h1;
		clks(20);
		dim_enable_i = 1'h0;
		clks(60);
		`CHK("short pulse", 1'h0, disconnect_gate_on_o)
		$display("test refusal done");
		// Twice-trip overcurrent
		start();
		sense_over_2x_i = 1'h1;
		clks(120);
		`CHK("2x fault", 1'h1, overcurrent_fault_o)
		`CHK("2x gate", 1'h0, disconnect_gate_on_o)
		sense_over_2x_i = 1'h0;
		clks(20);
		`CHK("fault held", 1'h1, overcurrent_fault_o)
		stop();
		$display("test fast trip done");
		// Held single-trip overcurrent
		start();
		sense_over_1x_i = 1'h1;
		ticks(OC1 - 5);
		`CHK("1x early", 1'h0, overcurrent_fault_o)
		ticks(10);
		`CHK("1x fault", 1'h1, overcurrent_fault_o)
		sense_over_1x_i = 1'h0;
		stop();
		$display("test slow trip done");
		// Detection: pin 0 shorted, then both pins dropping, pin 1 unused
		short_cmd = 2'h1;
		unused_cmd = 2'h2;
		start();
		`CHK("gate wait", 1'h0, short_halt_o)
		clks(30);
		`CHK("halt", 1'h1, short_halt_o)
		`CHK("halt sinks", 2'h0, sink_enable_o)
		short_cmd = 2'h0;
		ticks(2000);
		`CHK("halt clear", 1'h0, short_halt_o)
		`CHK("no soft", 1'h0, soft_start_o)
		drop = 1'h1;
		clks(20);
		drop = 1'h0;
		ticks(2900);
		`CHK("restart", 1'h0, soft_start_o)
		for (int i = 0; i < 7900 && soft_start_o !== 1'h1; i++) begin
			@(negedge clk_i);
		end
		`CHK("soft", 1'h1, soft_start_o)
		`CHK("unused", 2'h2, channel_unused_o)
		`CHK("mask", 2'h1, regulation_mask_o)
		`CHK("sinks on", 2'h1, sink_enable_o)
		clks(40);
		`CHK("run", 1'h1, startup_done_o)
		`CHK("soft off", 1'h0, soft_start_o)
		`CHK("uv select", 1'h1, uv_stop_select_o)
		uv_start_i = 1'h1;
		clks(20);
		`CHK("low supply run", 1'h1, startup_done_o)
		uv_stop_i = 1'h1;
		clks(20);
		`CHK("uv stop", 1'h0, disconnect_gate_on_o)
		$display("test detection done");
		final_report();
	end

endmodule : led_driver_powerup_sequencer_test
